// ---- sam_pkg.sv ----
/*
  Shared constants and types for the serial access mode control link:
  communications word layout, mode codes, register word lengths, link
  timing and the host's own register map.
  Assumes both ends are compiled after this package.
*/
package sam_pkg;

  // ----------------------------------------------------------------
  // Communications word layout
  // ----------------------------------------------------------------
  localparam int COMM_BITS = 8;
  localparam int POS_ACCESS_MODE_HI = 5;
  localparam int POS_ACCESS_MODE_LO = 4;
  localparam int POS_REG_SELECT_MSB = 2;
  localparam int POS_REG_SELECT_LSB = 0;
  localparam logic [1:0] MODE_SINGLE_WRITE = 2'h0;
  localparam logic [1:0] MODE_SINGLE_READ = 2'h1;
  localparam logic [1:0] MODE_CONT_READ = 2'h2;
  localparam logic [1:0] MODE_STOP_CONT = 2'h3;
  localparam logic [7:0] STOP_WORD = 8'h30;

  // ----------------------------------------------------------------
  // Register word lengths, indexed by register select
  // ----------------------------------------------------------------
  localparam int DATA_BITS = 24;
  localparam logic [4:0] LEN_BYTE = 5'h08;
  localparam logic [4:0] LEN_HALF = 5'h10;
  localparam logic [4:0] LEN_WIDE = 5'h18;
  // Consecutive ones on the data input that resynchronise the decoder.
  localparam logic [5:0] RESYNC_ONES = 6'h20;

  function automatic logic [4:0] reg_len(input logic [2:0] sel);
    case (sel)
      3'h0: reg_len = LEN_BYTE;
      3'h2: reg_len = LEN_HALF;
      3'h4: reg_len = LEN_BYTE;
      default: reg_len = LEN_WIDE;
    endcase
  endfunction : reg_len

  // ----------------------------------------------------------------
  // Link timing and host register map
  // ----------------------------------------------------------------
  localparam int PCLK_PERIOD_NS = 10;
  localparam int SCLK_HALF_NS = 40;
  localparam logic [3:0] SCLK_HALF_CYC = 4'(SCLK_HALF_NS / PCLK_PERIOD_NS);
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_WDATA = 8'h04;
  localparam logic [7:0] OFS_RDATA = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam int CMD_GO_BIT = 8;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_CONT_BIT = 1;

  typedef enum logic [1:0] {ds_comm, ds_write, ds_read, ds_cont} dev_state_t;

endpackage : sam_pkg

// ---- sam_link_if.sv ----
/*
  Three-wire serial link between the host end and the converter end.
  Assumes the host drives the serial clock and data in, and the device
  drives data out; all wires are point to point.
*/
`timescale 1ns/10ps
interface sam_link_if;
  logic sclk;
  logic din;
  logic dout;

  modport dev (
    input sclk,
    input din,
    output dout
  );

  modport host (
    output sclk,
    output din,
    input dout
  );
endinterface : sam_link_if

// ---- sam_device.sv ----
/*
  Converter end: decodes communications words arriving on the serial
  link and steers single writes, single reads and continuous reads of
  the selected register.
  Assumes the whole end runs on the link clock, the register bank sits
  in the same domain and answers rd_data combinationally from rd_sel.
*/
`timescale 1ns/10ps
module sam_device (
  input wire logic presetn,       // Asynchronous reset, active low.
  sam_link_if.dev link,           // Serial link, clocked by link.sclk.
  output logic wr_stb,            // One-cycle register write strobe.
  output logic [2:0] wr_sel,      // Register written.
  output logic [23:0] wr_data,    // Write data, right aligned.
  output logic [2:0] rd_sel,      // Register being read.
  input wire logic [23:0] rd_data, // Read data for rd_sel, right aligned.
  output logic cont_active,       // Continuous read in force.
  output logic [7:0] last_comm    // Last accepted communications word.
);

  // ----------------------------------------------------------------
  // Decoder state
  // ----------------------------------------------------------------
  sam_pkg::dev_state_t state;
  sam_pkg::dev_state_t next_state;
  logic [4:0] bit_cnt;
  logic [6:0] comm_sh;
  logic [4:0] len;
  logic [22:0] data_sh;
  logic [6:0] watch;
  logic [2:0] frame_cnt;
  logic [5:0] ones;
  logic [7:0] word;
  logic last_bit;
  logic resync;
  logic stop_seen;

  assign word = {comm_sh, link.din};
  assign last_bit = (bit_cnt == len - 5'h01);
  // A long run of ones puts the decoder back to the word boundary.
  assign resync = link.din && (ones == sam_pkg::RESYNC_ONES - 6'h01);
  // Stop is only recognised on byte boundaries of the continuous stream.
  assign stop_seen = (frame_cnt == 3'h7) && ({watch, link.din} == sam_pkg::STOP_WORD);

  always_comb begin
    next_state = state;
    if (resync) begin
      next_state = sam_pkg::ds_comm;
    end else begin
      case (state)
        sam_pkg::ds_comm: begin
          if (bit_cnt == 5'h07) begin
            case (word[sam_pkg::POS_ACCESS_MODE_HI:sam_pkg::POS_ACCESS_MODE_LO])
              sam_pkg::MODE_SINGLE_WRITE: next_state = sam_pkg::ds_write;
              sam_pkg::MODE_SINGLE_READ: next_state = sam_pkg::ds_read;
              sam_pkg::MODE_CONT_READ: next_state = sam_pkg::ds_cont;
              default: next_state = sam_pkg::ds_comm;
            endcase
          end
        end
        sam_pkg::ds_write, sam_pkg::ds_read: begin
          if (last_bit) begin
            next_state = sam_pkg::ds_comm;
          end
        end
        sam_pkg::ds_cont: begin
          if (stop_seen) begin
            next_state = sam_pkg::ds_comm;
          end
        end
        default: next_state = sam_pkg::ds_comm;
      endcase
    end
  end

  always_ff @(posedge link.sclk or negedge presetn) begin
    if (!presetn) begin
      state <= sam_pkg::ds_comm;
      cont_active <= 1'b0;
    end else begin
      state <= next_state;
      cont_active <= (next_state == sam_pkg::ds_cont);
    end
  end

  // ----------------------------------------------------------------
  // Bit counting and word capture
  // ----------------------------------------------------------------
  always_ff @(posedge link.sclk or negedge presetn) begin
    if (!presetn) begin
      bit_cnt <= 5'h00;
    end else if (resync || state != next_state) begin
      bit_cnt <= 5'h00;
    end else begin
      case (state)
        sam_pkg::ds_comm: begin
          if (bit_cnt == 5'h07) begin
            bit_cnt <= 5'h00;
          end else if (!(bit_cnt == 5'h00 && link.din)) begin
            // A one in the leading position parks the decoder there.
            bit_cnt <= bit_cnt + 5'h01;
          end
        end
        sam_pkg::ds_cont: begin
          bit_cnt <= last_bit ? 5'h00 : bit_cnt + 5'h01;
        end
        default: bit_cnt <= bit_cnt + 5'h01;
      endcase
    end
  end

  always_ff @(posedge link.sclk or negedge presetn) begin
    if (!presetn) begin
      comm_sh <= 7'h00;
      rd_sel <= 3'h0;
      len <= sam_pkg::LEN_BYTE;
      last_comm <= 8'h00;
    end else if (state == sam_pkg::ds_comm && !resync) begin
      if (!(bit_cnt == 5'h00 && link.din)) begin
        comm_sh <= {comm_sh[5:0], link.din};
      end
      if (bit_cnt == 5'h07) begin
        last_comm <= word;
        if (next_state != sam_pkg::ds_comm) begin
          rd_sel <= word[sam_pkg::POS_REG_SELECT_MSB:sam_pkg::POS_REG_SELECT_LSB];
          len <= sam_pkg::reg_len(word[sam_pkg::POS_REG_SELECT_MSB:sam_pkg::POS_REG_SELECT_LSB]);
        end
      end
    end else if (state == sam_pkg::ds_cont && stop_seen && !resync) begin
      // The stop word is a communications word too, though it arrives mid-stream.
      last_comm <= {watch, link.din};
    end
  end

  // ----------------------------------------------------------------
  // Single write path
  // ----------------------------------------------------------------
  always_ff @(posedge link.sclk or negedge presetn) begin
    if (!presetn) begin
      data_sh <= 23'h000000;
      wr_stb <= 1'b0;
      wr_sel <= 3'h0;
      wr_data <= 24'h000000;
    end else begin
      wr_stb <= 1'b0;
      if (state == sam_pkg::ds_write) begin
        data_sh <= {data_sh[21:0], link.din};
        if (last_bit && !resync) begin
          wr_stb <= 1'b1;
          wr_sel <= rd_sel;
          wr_data <= {data_sh, link.din};
        end
      end else begin
        data_sh <= 23'h000000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Watch for stop word and runs of ones
  // ----------------------------------------------------------------
  // The din line is sampled on every rising edge in continuous mode even while the device only
  // talks, since the stop word may arrive in the middle of a read.
  always_ff @(posedge link.sclk or negedge presetn) begin
    if (!presetn) begin
      watch <= 7'h00;
      frame_cnt <= 3'h0;
    end else if (state == sam_pkg::ds_cont && next_state == sam_pkg::ds_cont) begin
      watch <= {watch[5:0], link.din};
      frame_cnt <= frame_cnt + 3'h1;
    end else begin
      watch <= 7'h00;
      frame_cnt <= 3'h0;
    end
  end

  always_ff @(posedge link.sclk or negedge presetn) begin
    if (!presetn) begin
      ones <= 6'h00;
    end else if (!link.din || resync) begin
      ones <= 6'h00;
    end else begin
      ones <= ones + 6'h01;
    end
  end

  // ----------------------------------------------------------------
  // Read data out
  // ----------------------------------------------------------------
  // Data out changes on the falling edge so that the host, which samples
  // on the rising edge, sees half a clock of setup on every bit.
  always_ff @(negedge link.sclk or negedge presetn) begin
    if (!presetn) begin
      link.dout <= 1'b0;
    end else if (state == sam_pkg::ds_read || state == sam_pkg::ds_cont) begin
      link.dout <= rd_data[len - 5'h01 - bit_cnt];
    end else begin
      link.dout <= 1'b0;
    end
  end

endmodule : sam_device

// ---- sam_host.sv ----
/*
  Host end: an APB slave holding command, write data, read data and
  status registers, and a serial engine that makes the link clock from
  pclk by a divider and runs the transfers software orders.
  Assumes pclk at 100 MHz and the converter end on the other side.
*/
`timescale 1ns/10ps
module sam_host (
  input wire logic pclk,          // APB clock.
  input wire logic presetn,       // Asynchronous reset, active low.
  input wire logic psel,          // APB select.
  input wire logic penable,       // APB enable.
  input wire logic pwrite,        // APB direction.
  input wire logic [7:0] paddr,   // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata,     // APB read data.
  output logic pready,            // APB ready.
  output logic pslverr,           // APB error on unmapped address.
  sam_link_if.host link           // Serial link, clock made here.
);

  // ----------------------------------------------------------------
  // Registers and APB slave
  // ----------------------------------------------------------------
  logic [1:0] cmd_mode;
  logic [2:0] cmd_sel;
  logic [23:0] wdata;
  logic [23:0] rdata;
  logic busy;
  logic cont;
  logic [2:0] cont_sel;
  logic dout_meta;
  logic dout_sync;
  logic [31:0] tx;
  logic [23:0] rx;
  logic [5:0] bits_left;
  logic [3:0] div;
  logic access;
  logic go;
  logic mapped;
  logic [31:0] next_tx;
  logic [5:0] next_bits;
  logic [7:0] comm;
  logic [4:0] len;

  assign access = psel && penable && pready;
  assign mapped = (paddr == sam_pkg::OFS_CMD) || (paddr == sam_pkg::OFS_WDATA) ||
                  (paddr == sam_pkg::OFS_RDATA) || (paddr == sam_pkg::OFS_STATUS);
  // Commands given while a transfer runs are dropped; software polls busy.
  assign go = access && pwrite && paddr == sam_pkg::OFS_CMD && pwdata[sam_pkg::CMD_GO_BIT] && !busy;

  // No wait state: data and ready are registered in the setup cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= 32'h00000000;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          sam_pkg::OFS_CMD: prdata <= {26'h0000000, cmd_mode, 1'b0, cmd_sel};
          sam_pkg::OFS_WDATA: prdata <= {8'h00, wdata};
          sam_pkg::OFS_RDATA: prdata <= {8'h00, rdata};
          sam_pkg::OFS_STATUS: prdata <= {30'h00000000, cont, busy};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_mode <= sam_pkg::MODE_SINGLE_WRITE;
      cmd_sel <= 3'h0;
      wdata <= 24'h000000;
    end else if (access && pwrite) begin
      if (paddr == sam_pkg::OFS_CMD) begin
        cmd_mode <= pwdata[sam_pkg::POS_ACCESS_MODE_HI:sam_pkg::POS_ACCESS_MODE_LO];
        cmd_sel <= pwdata[sam_pkg::POS_REG_SELECT_MSB:sam_pkg::POS_REG_SELECT_LSB];
      end
      if (paddr == sam_pkg::OFS_WDATA) begin
        wdata <= pwdata[23:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Transfer set-up
  // ----------------------------------------------------------------
  assign comm = {2'h0, pwdata[5:4], 1'b0, pwdata[2:0]};
  assign len = sam_pkg::reg_len(cont ? cont_sel : pwdata[2:0]);

  always_comb begin
    next_tx = {comm, 24'h000000};
    next_bits = 6'(sam_pkg::COMM_BITS) + {1'b0, len};
    if (cont) begin
      if (pwdata[5:4] == sam_pkg::MODE_STOP_CONT) begin
        next_tx = {sam_pkg::STOP_WORD, 24'h000000};
        next_bits = 6'(sam_pkg::COMM_BITS);
      end else begin
        // Reads in continuous mode are whole register words, all byte
        // multiples, so a later stop word lands on a byte boundary.
        next_tx = 32'h00000000;
        next_bits = {1'b0, len};
      end
    end else begin
      case (pwdata[5:4])
        sam_pkg::MODE_SINGLE_WRITE: next_tx = {comm, wdata << (5'd24 - len)};
        sam_pkg::MODE_STOP_CONT: next_bits = 6'(sam_pkg::COMM_BITS);
        default: next_tx = {comm, 24'h000000};
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cont <= 1'b0;
      cont_sel <= 3'h0;
    end else if (go && pwdata[5:4] == sam_pkg::MODE_STOP_CONT) begin
      cont <= 1'b0;
    end else if (go && !cont && pwdata[5:4] == sam_pkg::MODE_CONT_READ) begin
      cont <= 1'b1;
      cont_sel <= pwdata[2:0];
    end
  end

  // ----------------------------------------------------------------
  // Serial engine
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dout_meta <= 1'b0;
      dout_sync <= 1'b0;
    end else begin
      dout_meta <= link.dout;
      dout_sync <= dout_meta;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
      div <= 4'h0;
      link.sclk <= 1'b0;
      link.din <= 1'b0;
      tx <= 32'h00000000;
      rx <= 24'h000000;
      bits_left <= 6'h00;
      rdata <= 24'h000000;
    end else if (go) begin
      busy <= 1'b1;
      div <= 4'h0;
      tx <= next_tx;
      link.din <= next_tx[31];
      rx <= 24'h000000;
      bits_left <= next_bits;
    end else if (busy) begin
      if (div == sam_pkg::SCLK_HALF_CYC - 4'h1) begin
        div <= 4'h0;
        if (!link.sclk) begin
          link.sclk <= 1'b1;
          rx <= {rx[22:0], dout_sync};
          bits_left <= bits_left - 6'h01;
        end else begin
          link.sclk <= 1'b0;
          if (bits_left == 6'h00) begin
            busy <= 1'b0;
            link.din <= 1'b0;
            rdata <= rx;
          end else begin
            tx <= {tx[30:0], 1'b0};
            link.din <= tx[30];
          end
        end
      end else begin
        div <= div + 4'h1;
      end
    end
  end

endmodule : sam_host

// ---- sam_link_chk.sv ----
/*
  Checker for the serial link between the host end and the converter end.
  Assumes it watches the link wires and the host clock and reset only.
*/
`timescale 1ns/10ps
module sam_link_chk (
  input wire logic pclk,    // Host clock, samples the wires.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic sclk,    // Link clock.
  input wire logic din,     // Host to device data.
  input wire logic dout     // Device to host data.
);
  // ----------------------------------------------------------------
  // Frame tracking
  // ----------------------------------------------------------------
  // A frame starts after six or more low samples; inside a frame the low phase is four.
  logic sclk_q;
  logic rise;
  logic [3:0] idle_cnt;
  logic [5:0] nbits;
  logic [5:0] idx;
  assign rise = sclk & ~sclk_q;
  assign idx = (idle_cnt >= 4'h6) ? 6'h00 : nbits;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sclk_q <= 1'b0;
    else sclk_q <= sclk;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) idle_cnt <= 4'h0;
    else if (sclk) idle_cnt <= 4'h0;
    else if (idle_cnt != 4'hf) idle_cnt <= idle_cnt + 4'h1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) nbits <= 6'h00;
    else if (rise) nbits <= idx + 6'h01;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_DIN_HOLD: assert property (sclk && sclk_q |-> $stable(din))
    else $error("din moved while sclk high");
  AST_DOUT_HOLD: assert property (sclk && sclk_q |-> $stable(dout))
    else $error("dout moved while sclk high");
  AST_SCLK_HIGH: assert property (rise |-> sclk [*4] ##1 !sclk)
    else $error("sclk high phase not four cycles");
  AST_SCLK_LOW: assert property (!sclk && sclk_q |-> !sclk [*4])
    else $error("sclk low phase under four cycles");
  AST_DOUT_AT_FALL: assert property ($changed(dout) |-> !sclk && sclk_q)
    else $error("dout changed away from a falling sclk");
  AST_FIRST_BIT_ZERO: assert property (rise && idx == 6'h00 |-> !din)
    else $error("frame started with din high");
  AST_ZERO_BITS: assert property (rise && (idx == 6'h01 || idx == 6'h04) |-> !din)
    else $error("reserved word bit sent high");
  AST_FRAME_LEN: assert property (rise |-> idx < 6'h20)
    else $error("frame longer than 32 bits");
  AST_WHOLE_BYTES: assert property (idle_cnt == 4'h6 |-> nbits[2:0] == 3'h0)
    else $error("frame not a whole number of bytes");
endmodule : sam_link_chk

// ---- testbench.sv ----
/*
  Self-checking bench: host and converter ends joined by one link, plus a
  lone converter end driven by a rule-breaking bench host on a second link.
  Assumes pclk at 100 MHz and a 125 ns link clock made by the bench.
*/
`timescale 1ns/10ps
module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic last_err;
  logic [31:0] q;
  logic [31:0] seed = 32'h4965;
  logic [31:0] rx2 = 32'h0;
  logic [23:0] bank [8];
  logic wr_stb, wr_stb2, cont_active, cont_active2;
  logic [2:0] wr_sel, wr_sel2, rd_sel, rd_sel2;
  logic [23:0] wr_data, wr_data2;
  logic [7:0] last_comm, last_comm2;
  int fail_count = 0;
  int n_tests = 0;
  int cycles = 0;

  always #5 pclk = ~pclk;

  sam_link_if lk ();
  sam_link_if lk2 ();
  sam_host sam_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(lk.host));
  sam_device sam_device_inst (.presetn(presetn), .link(lk.dev), .wr_stb(wr_stb),
    .wr_sel(wr_sel), .wr_data(wr_data), .rd_sel(rd_sel), .rd_data(bank[rd_sel]),
    .cont_active(cont_active), .last_comm(last_comm));
  sam_device lone_sam_device_inst (.presetn(presetn), .link(lk2.dev), .wr_stb(wr_stb2),
    .wr_sel(wr_sel2), .wr_data(wr_data2), .rd_sel(rd_sel2), .rd_data(bank[rd_sel2]),
    .cont_active(cont_active2), .last_comm(last_comm2));
  sam_link_chk chk_inst (.pclk(pclk), .presetn(presetn), .sclk(lk.sclk), .din(lk.din),
    .dout(lk.dout));

  // ----------------------------------------------------------------
  // Expectations and helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [23:0] mask(input logic [2:0] sel);
    case (sel)
      3'h0, 3'h4: mask = 24'h0000ff;
      3'h2: mask = 24'h00ffff;
      default: mask = 24'hffffff;
    endcase
  endfunction : mask

  function automatic logic [31:0] comm(input logic [1:0] mode, input logic [2:0] sel);
    comm = {24'h0, 2'b00, mode, 1'b0, sel};
  endfunction : comm

  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task go(input logic [1:0] mode, input logic [2:0] sel);
    apb(1'b1, sam_pkg::OFS_CMD, (32'h1 << sam_pkg::CMD_GO_BIT) | comm(mode, sel));
    q = 32'h1;
    while (q[sam_pkg::STATUS_BUSY_BIT] !== 1'b0) apb(1'b0, sam_pkg::OFS_STATUS, 32'h0);
  endtask : go

  // The lone link idles with data inverted so a stale level is never mistaken for data.
  task send2(input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      lk2.din = v[i];
      #62.5;
      rx2 = {rx2[30:0], lk2.dout};
      lk2.sclk = 1'b1;
      #62.5 lk2.sclk = 1'b0;
    end
    lk2.din = ~lk2.din;
  endtask : send2

  task print_verdict;
    $display("counts: %0d checks, %0d mismatches", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      $display("BAD t=%0t run timed out", $time);
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    lk2.sclk = 1'b0;
    lk2.din = 1'b0;
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      bank[i] = seed[23:0];
    end
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, sam_pkg::OFS_STATUS, 32'h0);
    check(q, 32'h0, "status after reset");
    apb(1'b0, 8'h10, 32'h0);
    check({31'h0, last_err}, 32'h1, "unmapped access");
    $display("test registers done");
    for (int s = 0; s < 8; s++) begin
      seed = lfsr(seed);
      apb(1'b1, sam_pkg::OFS_WDATA, {8'h00, seed[23:0]});
      go(sam_pkg::MODE_SINGLE_WRITE, s[2:0]);
      check({29'h0, wr_sel}, s, "write select");
      check({8'h0, wr_data}, {8'h0, seed[23:0] & mask(s[2:0])}, "write data");
      check({24'h0, last_comm}, comm(sam_pkg::MODE_SINGLE_WRITE, s[2:0]), "word");
      check({31'h0, cont_active}, 32'h0, "idle after write");
      check({31'h0, wr_stb}, 32'h1, "write strobe");
      seed = lfsr(seed);
      bank[s] = seed[23:0];
      go(sam_pkg::MODE_SINGLE_READ, s[2:0]);
      check({29'h0, rd_sel}, s, "read select");
      apb(1'b0, sam_pkg::OFS_RDATA, 32'h0);
      check(q, {8'h0, bank[s] & mask(s[2:0])}, "read data");
      check({31'h0, cont_active}, 32'h0, "idle after read");
      check({31'h0, wr_stb}, 32'h0, "strobe over");
    end
    $display("test single access done");
    go(sam_pkg::MODE_STOP_CONT, 3'h0);
    check({31'h0, cont_active}, 32'h0, "stop outside continuous");
    go(sam_pkg::MODE_CONT_READ, 3'h1);
    check({31'h0, cont_active}, 32'h1, "continuous entered");
    apb(1'b0, sam_pkg::OFS_RDATA, 32'h0);
    check(q, {8'h0, bank[1]}, "first continuous data");
    for (int k = 0; k < 3; k++) begin
      seed = lfsr(seed);
      // The next read's first bit already stands on dout when a read ends, so it is kept.
      bank[1] = {bank[1][23], seed[22:0]};
      go(k[1:0], seed[26:24]);
      apb(1'b0, sam_pkg::OFS_RDATA, 32'h0);
      check(q, {8'h0, bank[1]}, "continuous data");
      check({31'h0, cont_active}, 32'h1, "still continuous");
    end
    go(sam_pkg::MODE_STOP_CONT, 3'h0);
    check({31'h0, cont_active}, 32'h0, "continuous stopped");
    check({24'h0, last_comm}, {24'h0, sam_pkg::STOP_WORD}, "stop word");
    go(sam_pkg::MODE_SINGLE_READ, 3'h2);
    apb(1'b0, sam_pkg::OFS_RDATA, 32'h0);
    check(q, {8'h0, bank[2] & mask(3'h2)}, "read after stop");
    $display("test continuous read done");
    send2(32'h7, 3);
    send2(comm(sam_pkg::MODE_SINGLE_READ, 3'h2), 8);
    check({24'h0, last_comm2}, comm(sam_pkg::MODE_SINGLE_READ, 3'h2), "leading ones");
    check({29'h0, rd_sel2}, 32'h2, "lone read select");
    send2(32'h0, 16);
    check({16'h0, rx2[15:0]}, {8'h0, bank[2] & mask(3'h2)}, "lone read data");
    send2(comm(sam_pkg::MODE_CONT_READ, 3'h1), 8);
    send2(32'h0, 24);
    check({31'h0, cont_active2}, 32'h1, "lone continuous");
    send2(32'hffffffff, 32);
    check({31'h0, cont_active2}, 32'h0, "ones resync");
    send2(comm(sam_pkg::MODE_SINGLE_WRITE, 3'h4), 8);
    send2(32'ha5, 8);
    check({29'h0, wr_sel2}, 32'h4, "write after resync");
    check({8'h0, wr_data2}, 32'ha5, "data after resync");
    check({31'h0, wr_stb2}, 32'h1, "lone write strobe");
    $display("test faulty host done");
    print_verdict();
  end
endmodule : testbench
